// File: src/cip_pkg.sv
// Purpose: shared constants and types for the input power-up sequencer
// Assumes: 125 MHz mclk, analog comparators deliver synchronous levels
// Notes: all times are in milliseconds of the selected digital clock
package cip_pkg;
  localparam int unsigned MCLK_HZ = 125_000_000;
  localparam int unsigned FAST_DIG_HZ = 1_500_000;
  localparam int unsigned SLOW_DIG_HZ = 30_000;
  localparam int unsigned FAST_DIV_CYC = MCLK_HZ / FAST_DIG_HZ;
  localparam int unsigned SLOW_DIV_CYC = MCLK_HZ / SLOW_DIG_HZ;
  localparam int unsigned FAST_PER_MS = FAST_DIG_HZ / 1000;
  localparam int unsigned SLOW_PER_MS = SLOW_DIG_HZ / 1000;

  localparam int TMR_W = 12;
  localparam int MA_W = 12;
  localparam logic [TMR_W-1:0] QUAL_MS = 12'h01e;
  localparam logic [TMR_W-1:0] RETRY_MS = 12'h7d0;
  localparam logic [TMR_W-1:0] BIAS_DELAY_MS = 12'h0dc;
  localparam logic [TMR_W-1:0] REV_DELAY_MS = 12'h01e;
  localparam logic [TMR_W-1:0] DET_STEP_MS = 12'h064;
  localparam logic [TMR_W-1:0] BATDET_MS = 12'h032;
  localparam logic [2:0] FAIL_LIMIT = 3'h7;

  localparam logic [MA_W-1:0] SDP_MA = 12'h1f4;
  localparam logic [MA_W-1:0] CDP_MA = 12'h5dc;
  localparam logic [MA_W-1:0] DCP_MA = 12'hbb8;
  localparam logic [MA_W-1:0] DIV1_MA = 12'h834;
  localparam logic [MA_W-1:0] DIV3_MA = 12'h3e8;
  localparam logic [MA_W-1:0] DIV4_MA = 12'h960;
  localparam logic [MA_W-1:0] UNKNOWN_MA = 12'h1f4;
  localparam logic [MA_W-1:0] REVERSE_MA = 12'h7d0;

  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] LIMIT_OFS = 4'h8;
  localparam int CTRL_FORCE_HIZ_BIT = 0;
  localparam int CTRL_CHG_DIS_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SRC_NONE = 3'h0,
    SRC_SDP = 3'h1,
    SRC_CDP = 3'h2,
    SRC_DCP = 3'h3,
    SRC_DIV1 = 3'h4,
    SRC_DIV3 = 3'h5,
    SRC_DIV4 = 3'h6,
    SRC_UNKNOWN = 3'h7
  } cip_src_type;

  typedef struct packed {
    logic vbus_uvlo_ok;
    logic bat_uvlo_ok;
    logic vbus_ovp;
    logic vbus_above_weak;
    logic vbus_present;
    logic data_contact;
    logic primary_hit;
    logic secondary_hit;
    logic dp_upper;
    logic dp_lower;
    logic dm_upper;
    logic dm_lower;
    logic input_voltage_regulation_loop_active;
    logic ico_found;
    logic [MA_W-1:0] ico_limit_ma;
    logic [MA_W-1:0] current_limit_pin_pin_ma;
    logic bat_above_otg_min;
    logic otg_pin;
    logic ts_in_reverse_range;
    logic light_load;
    logic bat_below_minsys;
  } cip_sense_type;

  typedef struct packed {
    logic battery_switch_driver_active;
    logic battery_switch_on;
    logic weak_source_test_load;
    logic bias_enable;
    logic converter_enable;
    logic battery_detect_load;
    logic charge_allowed;
    logic pfm_enable;
    logic ico_enable;
    logic ico_rerun;
    logic reverse_enable;
    logic high_impedance_state;
    logic power_good_n;
    logic [MA_W-1:0] input_limit_ma;
    logic [MA_W-1:0] reverse_limit_ma;
  } cip_ctl_type;
endpackage : cip_pkg

// File: src/cip_tick_gen.sv
// Purpose: millisecond tick from a fast or low-power digital clock rate
// Assumes: fast_sel is a registered level
// Notes: rate changes take effect at once, on the running counts, without restarting them
`timescale 1ns/1ps
module cip_tick_gen
  import cip_pkg::*;
#(
  parameter int unsigned FAST_DIV = FAST_DIV_CYC,
  parameter int unsigned SLOW_DIV = SLOW_DIV_CYC
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic fast_sel,
  output logic ms_tick
);
  if (FAST_DIV < 1 || SLOW_DIV < 1 || FAST_DIV > 8191 || SLOW_DIV > 8191)
  begin : g_bad_div
    $error("cip_tick_gen: divider out of range");
  end

  logic [12:0] div_cnt;
  logic [10:0] per_ms_cnt;
  logic [12:0] div_last;
  logic [10:0] per_ms_last;
  logic dig_tick;

  assign div_last = fast_sel ? 13'(FAST_DIV - 1) : 13'(SLOW_DIV - 1);
  assign per_ms_last = fast_sel ? 11'(FAST_PER_MS - 1) : 11'(SLOW_PER_MS - 1);
  assign dig_tick = (div_cnt >= div_last);

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      div_cnt <= 13'h0000;
      per_ms_cnt <= 11'h000;
      ms_tick <= 1'b0;
    end
    else if (clk_en)
    begin
      ms_tick <= 1'b0;
      if (dig_tick)
      begin
        div_cnt <= 13'h0000;
        if (per_ms_cnt >= per_ms_last)
        begin
          per_ms_cnt <= 11'h000;
          ms_tick <= 1'b1;
        end
        else
          per_ms_cnt <= per_ms_cnt + 11'h001;
      end
      else
        div_cnt <= div_cnt + 13'h0001;
    end
  end
endmodule : cip_tick_gen

// File: src/cip_sequencer.sv
// Purpose: power-up sequencing of the charger from its input port
// Assumes: sense levels are synchronous to mclk; AXI4-Lite register access
// Notes: analog loops are outside; this block only issues enables and limits
`timescale 1ns/1ps
module cip_sequencer
  import cip_pkg::*;
#(
  parameter int unsigned FAST_DIV = FAST_DIV_CYC,
  parameter int unsigned SLOW_DIV = SLOW_DIV_CYC
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  input wire cip_sense_type sense,
  output cip_ctl_type ctl,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_QUAL = 8'h02,
    ST_RETRY = 8'h04,
    ST_OVP_WAIT = 8'h08,
    ST_LOCKOUT = 8'h10,
    ST_DETECT = 8'h20,
    ST_BIAS_WAIT = 8'h40,
    ST_RUN = 8'h80
  } cip_state_type;

  typedef enum logic [2:0] {
    DET_CONTACT = 3'h1,
    DET_PRIMARY = 3'h2,
    DET_SECONDARY = 3'h4
  } cip_det_type;

  function automatic logic [MA_W-1:0] min_ma(input logic [MA_W-1:0] a,
                                             input logic [MA_W-1:0] b);
    min_ma = (a < b) ? a : b;
  endfunction : min_ma

  function automatic logic [MA_W-1:0] src_limit(input cip_src_type s);
    unique case (s)
      SRC_SDP: src_limit = SDP_MA;
      SRC_CDP: src_limit = CDP_MA;
      SRC_DCP: src_limit = DCP_MA;
      SRC_DIV1: src_limit = DIV1_MA;
      SRC_DIV3: src_limit = DIV3_MA;
      SRC_DIV4: src_limit = DIV4_MA;
      default: src_limit = UNKNOWN_MA;
    endcase
  endfunction : src_limit

  cip_state_type state, next_state;
  cip_det_type det_step;
  cip_src_type src;
  logic [TMR_W-1:0] tmr;
  logic [TMR_W-1:0] rev_tmr;
  logic [2:0] fail_cnt;
  logic weak_seen;
  logic det_done;
  logic step_adv;
  logic ms_tick;
  logic [1:0] ctrl;
  logic ico_locked;
  logic [MA_W-1:0] ico_hold;
  logic input_voltage_regulation_loop_prev;
  logic ovp_prev;
  logic ico_restart;
  logic rev_ok;
  logic [MA_W-1:0] base_limit;
  logic [MA_W-1:0] ico_value;
  logic [MA_W-1:0] next_limit;
  logic force_hiz;
  logic chg_dis;
  logic wr_addr_held;
  logic wr_data_held;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  assign force_hiz = ctrl[CTRL_FORCE_HIZ_BIT];
  assign chg_dis = ctrl[CTRL_CHG_DIS_BIT];

  cip_tick_gen #(
    .FAST_DIV(FAST_DIV),
    .SLOW_DIV(SLOW_DIV)
  ) u_tick (
    .mclk(mclk),
    .reset(reset),
    .clk_en(clk_en),
    .fast_sel(ctl.bias_enable),
    .ms_tick(ms_tick)
  );

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
        next_state = ST_QUAL;
      ST_QUAL:
        if (sense.vbus_ovp)
          next_state = ST_OVP_WAIT;
        else if (tmr >= QUAL_MS)
        begin
          if (!weak_seen)
            next_state = ST_DETECT;
          else if (fail_cnt == FAIL_LIMIT - 3'h1)
            next_state = ST_LOCKOUT;
          else
            next_state = ST_RETRY;
        end
      ST_RETRY:
        if (sense.vbus_ovp)
          next_state = ST_OVP_WAIT;
        else if (tmr >= RETRY_MS)
          next_state = ST_QUAL;
      ST_OVP_WAIT:
        if (!sense.vbus_ovp)
          next_state = ST_QUAL;
      ST_LOCKOUT:
        next_state = ST_LOCKOUT;
      ST_DETECT:
        if (sense.vbus_ovp)
          next_state = ST_OVP_WAIT;
        else if (det_done)
          next_state = ST_BIAS_WAIT;
      ST_BIAS_WAIT:
        if (sense.vbus_ovp)
          next_state = ST_OVP_WAIT;
        else if (tmr >= BIAS_DELAY_MS)
          next_state = ST_RUN;
      ST_RUN:
        if (sense.vbus_ovp)
          next_state = ST_OVP_WAIT;
      default:
        next_state = ST_IDLE;
    endcase
    if (!sense.vbus_uvlo_ok)
      next_state = ST_IDLE;
    else if (force_hiz && state != ST_LOCKOUT)
      next_state = ST_IDLE;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      state <= ST_IDLE;
    else if (clk_en)
      state <= next_state;
  end

  // one timer serves every sequence step
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      tmr <= '0;
    else if (clk_en)
    begin
      if (next_state != state || step_adv)
        tmr <= '0;
      else if (ms_tick && tmr != '1)
        tmr <= tmr + 12'h001;
    end
  end

  // sag anywhere in the window fails
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      weak_seen <= 1'b0;
    else if (clk_en)
    begin
      if (state != ST_QUAL)
        weak_seen <= 1'b0;
      else if (!sense.vbus_above_weak)
        weak_seen <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      fail_cnt <= 3'h0;
    else if (clk_en)
    begin
      if (!sense.vbus_uvlo_ok || next_state == ST_DETECT)
        fail_cnt <= 3'h0;
      else if (state == ST_QUAL &&
               (next_state == ST_RETRY || next_state == ST_LOCKOUT))
        fail_cnt <= fail_cnt + 3'h1;
    end
  end

  always_comb
  begin
    step_adv = 1'b0;
    if (state == ST_DETECT && !det_done)
    begin
      if (det_step == DET_CONTACT)
        step_adv = sense.data_contact;
      else if (det_step == DET_PRIMARY)
        step_adv = (tmr >= DET_STEP_MS) && sense.primary_hit;
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      det_step <= DET_CONTACT;
      det_done <= 1'b0;
      src <= SRC_NONE;
    end
    else if (clk_en)
    begin
      if (state != ST_DETECT && next_state == ST_DETECT)
      begin
        det_step <= DET_CONTACT;
        det_done <= 1'b0;
        src <= SRC_NONE;
      end
      else if (!sense.vbus_uvlo_ok)
      begin
        det_done <= 1'b0;
        src <= SRC_NONE;
      end
      else if (state == ST_DETECT && !det_done)
      begin
        unique case (det_step)
          DET_CONTACT:
            if (sense.data_contact)
              det_step <= DET_PRIMARY;
            else if (tmr >= DET_STEP_MS)
            begin
              det_done <= 1'b1;
              if (sense.dp_upper && sense.dm_upper)
                src <= SRC_DIV4;
              else if (sense.dp_upper && sense.dm_lower)
                src <= SRC_DIV1;
              else if (sense.dp_lower && sense.dm_upper)
                src <= SRC_DIV3;
              else
                src <= SRC_UNKNOWN;
            end
          DET_PRIMARY:
            if (tmr >= DET_STEP_MS)
            begin
              if (sense.primary_hit)
                det_step <= DET_SECONDARY;
              else
              begin
                src <= SRC_SDP;
                det_done <= 1'b1;
              end
            end
          DET_SECONDARY:
            if (tmr >= DET_STEP_MS)
            begin
              src <= sense.secondary_hit ? SRC_DCP : SRC_CDP;
              det_done <= 1'b1;
            end
          default:
            det_step <= DET_CONTACT;
        endcase
      end
    end
  end

  assign ico_restart = (state == ST_IDLE && next_state == ST_QUAL) ||
                       (sense.input_voltage_regulation_loop_active && !input_voltage_regulation_loop_prev) ||
                       (sense.vbus_ovp && !ovp_prev);

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      input_voltage_regulation_loop_prev <= 1'b0;
      ovp_prev <= 1'b0;
      ico_locked <= 1'b0;
      ico_hold <= '0;
    end
    else if (clk_en)
    begin
      input_voltage_regulation_loop_prev <= sense.input_voltage_regulation_loop_active;
      ovp_prev <= sense.vbus_ovp;
      if (ico_restart)
        ico_locked <= 1'b0;
      else if (ctl.ico_enable && sense.ico_found && !ico_locked)
      begin
        ico_locked <= 1'b1;
        ico_hold <= sense.ico_limit_ma;
      end
    end
  end

  assign base_limit = min_ma(sense.current_limit_pin_pin_ma, src_limit(src));
  assign ico_value = ico_locked ? ico_hold : sense.ico_limit_ma;
  assign next_limit = (src == SRC_DCP) ? min_ma(base_limit, ico_value)
                                       : base_limit;

  assign rev_ok = sense.bat_above_otg_min && !sense.vbus_present &&
                  sense.otg_pin && sense.ts_in_reverse_range;

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      rev_tmr <= '0;
    else if (clk_en)
    begin
      if (!rev_ok)
        rev_tmr <= '0;
      else if (ms_tick && rev_tmr != '1)
        rev_tmr <= rev_tmr + 12'h001;
    end
  end

  // every output registered
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      ctl <= '{power_good_n: 1'b1, high_impedance_state: 1'b1, default: '0};
    else if (clk_en)
    begin
      ctl.battery_switch_driver_active <= sense.vbus_uvlo_ok ||
                                          sense.bat_uvlo_ok;
      ctl.battery_switch_on <= sense.bat_uvlo_ok;
      ctl.weak_source_test_load <= (next_state == ST_QUAL);
      ctl.bias_enable <= (next_state == ST_RUN);
      ctl.high_impedance_state <= (next_state != ST_RUN);
      ctl.converter_enable <= (next_state == ST_RUN);
      ctl.battery_detect_load <= (next_state == ST_RUN) &&
                                 (state != ST_RUN || tmr < BATDET_MS);
      ctl.charge_allowed <= (next_state == ST_RUN) && state == ST_RUN &&
                            tmr >= BATDET_MS && !chg_dis;
      ctl.pfm_enable <= (next_state == ST_RUN) && sense.light_load &&
                        (sense.bat_below_minsys || chg_dis);
      ctl.ico_enable <= (src == SRC_DCP) &&
                        (next_state == ST_BIAS_WAIT || next_state == ST_RUN);
      ctl.ico_rerun <= ico_restart;
      ctl.reverse_enable <= rev_ok && rev_tmr >= REV_DELAY_MS;
      ctl.reverse_limit_ma <= REVERSE_MA;
      ctl.power_good_n <= !(next_state == ST_BIAS_WAIT ||
                            next_state == ST_RUN);
      ctl.input_limit_ma <= next_limit;
    end
  end

  // write channel: address and data taken in either order
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      wr_addr_held <= 1'b0;
      wr_data_held <= 1'b0;
      wr_addr <= '0;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
      ctrl <= CTRL_RESET;
    end
    else if (clk_en)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        wr_addr <= s_axi_awaddr;
        wr_addr_held <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
        wr_data_held <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_addr_held && wr_data_held && !s_axi_bvalid)
      begin
        s_axi_bvalid <= 1'b1;
        wr_addr_held <= 1'b0;
        wr_data_held <= 1'b0;
        if (wr_addr[ADDR_W-1:2] == CTRL_OFS[ADDR_W-1:2])
        begin
          s_axi_bresp <= RESP_OKAY;
          if (wr_strb[0])
            ctrl <= wr_data[1:0];
        end
        else if (wr_addr[ADDR_W-1:2] == STATUS_OFS[ADDR_W-1:2] ||
                 wr_addr[ADDR_W-1:2] == LIMIT_OFS[ADDR_W-1:2])
          s_axi_bresp <= RESP_OKAY;
        else
          s_axi_bresp <= RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read channel: one outstanding read
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        if (s_axi_araddr[ADDR_W-1:2] == CTRL_OFS[ADDR_W-1:2])
          s_axi_rdata <= {30'h0000_0000, ctrl};
        else if (s_axi_araddr[ADDR_W-1:2] == STATUS_OFS[ADDR_W-1:2])
          s_axi_rdata <= {15'h0000, ico_locked, ctl.reverse_enable,
                          ctl.power_good_n, fail_cnt, src, state};
        else if (s_axi_araddr[ADDR_W-1:2] == LIMIT_OFS[ADDR_W-1:2])
          s_axi_rdata <= {4'h0, src_limit(src), 4'h0, ctl.input_limit_ma};
        else
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule : cip_sequencer

// File: verification/cip_seq_assertions.sv
// Purpose: temporal checks on the sequencer outputs
// Assumes: clk_en high while checks matter
// Notes: delays counted in mclk cycles
`timescale 1ns/1ps
module cip_seq_checker
  import cip_pkg::*;
#(
  parameter int unsigned SLOW_DIV = SLOW_DIV_CYC
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  input wire cip_sense_type sense,
  input wire cip_ctl_type ctl
);
  logic [19:0] rev_cnt;
  logic rev_ok;
  assign rev_ok = sense.bat_above_otg_min && !sense.vbus_present &&
    sense.otg_pin && sense.ts_in_reverse_range;
  // saturates so a long wait never wraps to a false low count
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      rev_cnt <= 20'h0;
    else if (!rev_ok)
      rev_cnt <= 20'h0;
    else if (rev_cnt != 20'hfffff)
      rev_cnt <= rev_cnt + 20'h1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  drv_active_a: assert property (
    clk_en && (sense.vbus_uvlo_ok || sense.bat_uvlo_ok)
    |=> ctl.battery_switch_driver_active) else $error("driver idle");
  bat_only_a: assert property (
    clk_en && sense.bat_uvlo_ok && !sense.vbus_uvlo_ok
    |=> ctl.battery_switch_on && !ctl.bias_enable) else $error("bat only");
  pg_order_a: assert property (
    $fell(ctl.power_good_n) |-> !ctl.bias_enable
    && !ctl.weak_source_test_load) else $error("order broken");
  qual_load_a: assert property (
    ctl.weak_source_test_load |-> ctl.high_impedance_state
    && ctl.power_good_n) else $error("load misplaced");
  bias_gate_a: assert property (
    $rose(ctl.bias_enable) |-> $past(sense.vbus_uvlo_ok)
    && $past(ctl.power_good_n, 8) == 1'b0) else $error("bias early");
  bias_run_a: assert property (
    ctl.bias_enable |-> !ctl.high_impedance_state
    && ctl.converter_enable) else $error("bias state");
  limit_min_a: assert property (
    !ctl.power_good_n && $stable(sense.current_limit_pin_pin_ma)
    |-> ctl.input_limit_ma <= sense.current_limit_pin_pin_ma) else $error("limit high");
  pg_release_a: assert property (
    clk_en && !sense.vbus_uvlo_ok |=> ctl.power_good_n)
    else $error("pg stuck");
  light_load_a: assert property (
    ctl.pfm_enable |-> ctl.bias_enable) else $error("light load");
  rev_delay_a: assert property (
    $rose(ctl.reverse_enable) |-> rev_cnt >= 29 * 30 * SLOW_DIV)
    else $error("reverse early");
  rev_limit_a: assert property (
    ctl.reverse_enable |-> ctl.reverse_limit_ma == 12'h7d0)
    else $error("reverse limit");
  bias_up_c: cover property ($rose(ctl.bias_enable));
  optimizer_c: cover property ($rose(ctl.ico_enable));
  reverse_c: cover property ($rose(ctl.reverse_enable));
endmodule : cip_seq_checker
bind cip_sequencer cip_seq_checker #(.SLOW_DIV(SLOW_DIV)) u_chk (
  .mclk(mclk), .reset(reset), .clk_en(clk_en), .sense(sense), .ctl(ctl));

// File: verification/cip_adapter_model.sv
// Purpose: input adapter and battery seen by the sequencer
// Assumes: attach models plug state, kind the source type
// Notes: data lines pulled down when unplugged
`timescale 1ns/1ps
module cip_adapter_model
  import cip_pkg::*;
(
  input wire logic attach,
  input wire cip_src_type kind,
  input wire logic ovp,
  input wire logic otg,
  output cip_sense_type sense
);
  always_comb
  begin
    sense = '0;
    sense.bat_uvlo_ok = 1'b1;
    sense.bat_above_otg_min = 1'b1;
    sense.ts_in_reverse_range = 1'b1;
    sense.current_limit_pin_pin_ma = 12'hc80;
    sense.ico_limit_ma = 12'h9c4;
    sense.otg_pin = otg && !attach;
    if (attach)
    begin
      sense.vbus_uvlo_ok = 1'b1;
      sense.vbus_present = 1'b1;
      sense.vbus_ovp = ovp;
      sense.vbus_above_weak = 1'b1;
      sense.ico_found = 1'b1;
      sense.light_load = 1'b1;
      sense.data_contact = kind inside {SRC_SDP, SRC_CDP, SRC_DCP};
      sense.primary_hit = kind inside {SRC_CDP, SRC_DCP};
      sense.secondary_hit = kind == SRC_DCP;
      sense.dp_upper = kind inside {SRC_DIV1, SRC_DIV4};
      sense.dm_upper = kind inside {SRC_DIV3, SRC_DIV4};
      sense.dp_lower = kind == SRC_DIV3;
      sense.dm_lower = kind == SRC_DIV1;
    end
  end
endmodule : cip_adapter_model

// File: verification/charger_input_powerup_sequencer_tb.sv
// Purpose: self-checking bench for the input sequencer
// Assumes: divider parameters at 1 to keep timers short
// Notes: lockout needs seconds of retries, too long for this bench
`timescale 1ns/1ps
module charger_input_powerup_sequencer_tb;
  import cip_pkg::*;
  logic mclk = 1'b0, reset = 1'b1, attach = 1'b0, ovp = 1'b0, otg = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rr;
  cip_src_type kind = SRC_SDP;
  cip_sense_type sense;
  cip_ctl_type ctl;
  int err_total = 0, n_compared = 0, t;
  cip_src_type kinds [5] = '{SRC_DCP, SRC_DIV1, SRC_DIV3, SRC_DIV4, SRC_CDP};
  logic [11:0] lims [5] = '{12'h9c4, 12'h834, 12'h3e8, 12'h960, 12'h5dc};
  always #4 mclk = ~mclk;
  cip_adapter_model PM (.attach(attach), .kind(kind), .ovp(ovp),
    .otg(otg), .sense(sense));
  cip_sequencer #(.FAST_DIV(1), .SLOW_DIV(1)) DUT (.mclk(mclk),
    .reset(reset), .clk_en(1'b1), .sense(sense), .ctl(ctl),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic rd_reg(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask : rd_reg
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    logic aw_open;
    logic w_open;
    aw_open = 1'b1;
    w_open = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // each channel released at its own handshake
    while (aw_open || w_open)
    begin
      @(posedge mclk);
      if (aw_open && awready === 1'b1)
      begin
        aw_open = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_open && wready === 1'b1)
      begin
        w_open = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (bvalid !== 1'b1);
    rr = bresp;
    bready <= 1'b0;
  endtask : wr_reg
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  initial
  begin
    #480000;
    err_total++;
    end_sim();
  end
  initial
  begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(ctl.battery_switch_on, 1'b1, "switch");
    chk(ctl.battery_switch_driver_active, 1'b1, "driver");
    chk(ctl.bias_enable, 1'b0, "bias");
    rd_reg(4'hc);
    chk(rd, 32'h0, "unmapped data");
    chk(rr, RESP_SLVERR, "unmapped resp");
    wr_reg(4'h0, 32'h2);
    chk(rr, RESP_OKAY, "write resp");
    rd_reg(4'h0);
    chk(rd[1:0], 2'h2, "ctrl");
    wr_reg(4'h0, 32'h0);
    $display("register test done");
    ovp <= 1'b1;
    attach <= 1'b1;
    repeat (1000) @(posedge mclk);
    rd_reg(4'h4);
    chk(rd[7:0], 8'h08, "ovp wait");
    ovp <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(ctl.weak_source_test_load, 1'b1, "requalify");
    while (ctl.power_good_n !== 1'b0) @(posedge mclk);
    chk(ctl.input_limit_ma, 12'h1f4, "sdp limit");
    chk(ctl.ico_enable, 1'b0, "sdp optimizer");
    t = 0;
    while (ctl.bias_enable !== 1'b1)
    begin
      @(posedge mclk);
      t++;
    end
    chk(t >= (BIAS_DELAY_MS - 1) * SLOW_PER_MS, 1'b1, "bias min");
    chk(t <= BIAS_DELAY_MS * SLOW_PER_MS + 2, 1'b1, "bias max");
    chk(ctl.battery_detect_load, 1'b1, "bat detect");
    chk(ctl.high_impedance_state, 1'b0, "running");
    chk(ctl.pfm_enable, 1'b0, "pfm off");
    wr_reg(4'h0, 32'h2);
    repeat (2) @(posedge mclk);
    chk(ctl.pfm_enable, 1'b1, "pfm on");
    wr_reg(4'h0, 32'h0);
    attach <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(ctl.power_good_n, 1'b1, "pg release");
    $display("ovp and sdp test done");
    for (int i = 0; i < 5; i++)
    begin
      kind <= kinds[i];
      attach <= 1'b1;
      while (ctl.power_good_n !== 1'b0) @(posedge mclk);
      chk(ctl.input_limit_ma, lims[i], "limit");
      chk(ctl.ico_enable, kinds[i] == SRC_DCP, "optimizer");
      rd_reg(4'h4);
      chk(rd[10:8], kinds[i], "source");
      attach <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    $display("source type test done");
    otg <= 1'b1;
    t = 0;
    while (ctl.reverse_enable !== 1'b1)
    begin
      @(posedge mclk);
      t++;
    end
    chk(t >= 870, 1'b1, "reverse delay");
    chk(ctl.reverse_limit_ma, 12'h7d0, "reverse limit");
    $display("reverse test done");
    end_sim();
  end
endmodule : charger_input_powerup_sequencer_tb
